// ### hdl/windowed_reset_watchdog.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_cfg.svh"

// ==========================================
// Supervisory timer with APB control register
module windowed_reset_watchdog #(
  parameter int TICK_CYC = `TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  input  wire logic        opt_always_on,
  input  wire logic        opt_reset_on_stop,
  input  wire logic        stop_exec,
  input  wire logic        ext_wake,
  output var  logic        device_reset_n,
  output var  logic        osc_halted
);
  import wdog_pkg::*;

  // ==========================================
  // Local widths
  // Counter widths follow the counts they hold;
  // the pulse counter is sized for 20 cycles at
  // 40 MHz and must grow if the clock speeds up.
  localparam int PW = $clog2(TICK_CYC);   // Prescaler bits
  localparam int WW = $clog2(`WAKE_CYC);  // Wake delay bits
  localparam int RW = 5;                  // Pulse counter bits

  localparam logic [PW-1:0] TICK_LAST =
    PW'(TICK_CYC - 1);
  localparam logic [WW-1:0] WAKE_LAST =
    WW'(`WAKE_CYC - 1);
  localparam logic [RW-1:0] PULSE_LEN =
    RW'(`PULSE_CYC);

  // ==========================================
  // Declarations
  ctrl_t          ctrl_q;      // Control register
  osc_state_t     state_q;     // Oscillator state
  logic [PW-1:0]  presc_q;     // CPU cycle prescaler
  logic [WW-1:0]  wake_q;      // Wake delay count
  logic [RW-1:0]  pulse_q;     // Reset pulse length
  logic           pready_q;    // Bus answer
  logic [31:0]    prdata_q;    // Read data
  logic           pslverr_q;   // Unmapped flag
  logic           rst_out_q;   // Reset pin level
  logic [2:0]     pins_s;      // Synced pins
  opt_t           opt;         // Synced options
  logic           wake_s;      // Synced wake
  logic           tick;        // Decrement strobe
  logic           running;     // Oscillator on
  logic           eff_active;  // Watchdog armed
  logic           bus_wr;      // Write taken
  logic           hit;         // Address match
  logic           expire;      // Rollover event
  logic           sw_reset;    // Software reset
  logic           stop_reset;  // Stop reset
  logic           fire;        // Any reset cause
  logic           do_halt;     // Enter halt
  logic [7:0]     wr_byte;     // Written value
  logic           setup_ph;    // APB setup cycle

  // ==========================================
  // Helpers
  // The decode is shared by the write and the answer
  // logic; the readback word is built here too.

  // Decode of the single mapped word
  function automatic logic addr_hit(
    input logic [7:0] a
  );
    addr_hit = (a == `CTRL_OFFSET);
  endfunction

  // Readback word, upper bits zero
  function automatic logic [31:0] rd_word(
    input ctrl_t c,
    input logic  hw_on
  );
    logic [7:0] b;
    b = {c.active | hw_on, c.count};
    rd_word = {24'h0, b};
  endfunction

  // ==========================================
  // Pin synchronisers
  // Option straps and wake come from outside
  // the clock domain, so two stages first.
  sync2 #(
    .W(3)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({opt_always_on, opt_reset_on_stop,
             ext_wake}),
    .q     (pins_s)
  );

  // Straps land as one struct, in the order of
  // the synchroniser's input concatenation
  assign opt    = opt_t'(pins_s[2:1]);
  assign wake_s = pins_s[0];

  // ==========================================
  // Bus decode
  assign hit     = addr_hit(paddr);
  // Setup phase of any transfer, shared by the
  // three answer registers below
  assign setup_ph = psel & !penable;
  assign bus_wr  = psel & penable & pready_q &
                   pwrite & hit;
  // Low byte lane carries the register
  assign wr_byte = pwdata[7:0];

  // Armed by software bit or hardware option
  assign eff_active = ctrl_q.active |
                      opt.always_on;

  // Counting only while oscillator runs; the
  // idle instruction has no input here at all
  assign running = (state_q == ST_RUN);

  // ==========================================
  // Reset causes
  // Each cause is a one-cycle strobe; they are
  // merged into one pulse request below, so two
  // causes together give one pulse, not two.
  // Timer expiry when top bit clears
  assign expire = eff_active & running & tick &
                  (ctrl_q.count ==
                   `COUNT_EXPIRE);

  // Armed write with top bit clear
  assign sw_reset = bus_wr & pstrb[0] &
                    (wr_byte[`ACTIVE_BIT] |
                     eff_active) &
                    !wr_byte[`TOP_BIT];

  // Stop instruction with reset option
  assign stop_reset = stop_exec & running &
                      opt.reset_on_stop &
                      eff_active;

  // Plain stop halts the oscillator
  assign do_halt = stop_exec & running &
                   !stop_reset;

  assign fire = expire | sw_reset | stop_reset;

  // ==========================================
  // Prescaler
  // Free running; a reload does not restart it,
  // so the first increment may be short. The
  // trade keeps the bus path free of any reset
  // of this counter; software sees at most one
  // increment of jitter on each timeout.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
    end else if (!running) begin
      // Frozen while halted or waking
      presc_q <= presc_q;
    end else if (presc_q == TICK_LAST) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + PW'(1);
    end
  end

  // One decrement per full prescaler period
  assign tick = running &
                (presc_q == TICK_LAST);

  // ==========================================
  // Control register
  // A write in the same cycle as a tick wins and
  // that decrement is lost; an expiry raised by
  // that tick still fires, so a late reload
  // cannot cancel a reset already due.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Disabled, count all ones
      ctrl_q <= ctrl_t'(`CTRL_RESET);
    end else if (bus_wr && pstrb[0]) begin
      // Activation is sticky; zero is ignored
      ctrl_q.active <= ctrl_q.active |
                       wr_byte[`ACTIVE_BIT];
      // Write loads the countdown at once
      ctrl_q.count <= wr_byte[6:0];
    end else if (tick) begin
      // Decrements whether armed or not
      ctrl_q.count <= ctrl_q.count -
                      7'h01;
    end
  end

  // ==========================================
  // Oscillator state
  // Wake is read only after the synchroniser, so
  // the delay starts two cycles after the pin.
  // An unused code falls back to running.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          // Stop without reset option, or with it while not armed
          if (do_halt) begin
            state_q <= ST_HALT;
          end
        end
        ST_HALT: begin
          // Only an external event wakes
          if (wake_s) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Hold off counting for the delay
          if (wake_q == WAKE_LAST) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================
  // Wake delay counter
  // Counts only in the wake state and clears
  // elsewhere, so a second halt starts afresh
  // and the delay is the same every time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= '0;
    end else if (state_q == ST_WAKE) begin
      wake_q <= wake_q + WW'(1);
    end else begin
      wake_q <= '0;
    end
  end

  // ==========================================
  // Reset pulse
  // The pulse holds low for a fixed length; a
  // cause during the pulse restarts it. The
  // block itself is cleared by the system reset
  // that this pulse provokes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= '0;
    end else if (fire) begin
      // Load the remaining low cycles
      pulse_q <= PULSE_LEN - RW'(1);
    end else if (pulse_q != '0) begin
      // Count the low time down
      pulse_q <= pulse_q - RW'(1);
    end else begin
      // Nothing pending
      pulse_q <= '0;
    end
  end

  // Pin level: low on any cause and while the
  // counter runs; a flop keeps it glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Released while the block itself resets
      rst_out_q <= 1'b1;
    end else if (fire || (pulse_q != '0)) begin
      rst_out_q <= 1'b0;
    end else begin
      // Pulse over, pin back high
      rst_out_q <= 1'b1;
    end
  end

  // ==========================================
  // APB answer
  // Ready rises after the setup cycle, giving
  // zero wait states in the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (setup_ph) begin
      // Setup seen: answer in the access phase
      pready_q <= 1'b1;
    end else begin
      // Access done or idle
      pready_q <= 1'b0;
    end
  end

  // Error flag: only the one mapped word answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      // Unmapped address refused, no effect
      pslverr_q <= !hit;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Read data: a snapshot from the setup cycle,
  // so a tick in the access cycle is not seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_ph && !pwrite && hit) begin
      // Live state of the timer
      prdata_q <= rd_word(ctrl_q, opt.always_on);
    end else begin
      // Zero outside a read answer
      prdata_q <= '0;
    end
  end

  // ==========================================
  // Outputs straight from flip-flops
  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign device_reset_n = rst_out_q;
  // Bit 0 is set in halt and wake alike
  assign osc_halted     = state_q[0];

endmodule

`default_nettype wire

// ### hdl/wdog_cfg.svh
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH

// ==========================================
// Register map
`define CTRL_OFFSET     8'h24
`define CTRL_RESET      8'h7F
`define ACTIVE_BIT      7
`define TOP_BIT         6
`define COUNT_EXPIRE    7'h40

// ==========================================
// Timing
`define CLK_MHZ         40
`define PULSE_NS        500
`define PULSE_CYC       ((`PULSE_NS * `CLK_MHZ) / 1000)
`define TICK_CYC        12288
`define WAKE_CYC        4096

`endif

// ### hdl/wdog_pkg.sv
package wdog_pkg;

  // ==========================================
  // Control register contents
  typedef struct packed {
    logic       active;  // Activation bit
    logic [6:0] count;   // Countdown value
  } ctrl_t;

  // ==========================================
  // Oscillator / wake sequencing, Gray up to wake; wake to run flips both bits
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,  // Oscillator running
    ST_HALT = 2'b01,  // Stopped, frozen
    ST_WAKE = 2'b11   // Wake delay running
  } osc_state_t;

  // Option straps after synchronising
  typedef struct packed {
    logic always_on;     // Hardware watchdog
    logic reset_on_stop; // Reset on stop
  } opt_t;

endpackage

// ### hdl/sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Two-stage level synchroniser
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;  // First stage, read by q only

  // Both stages clear under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ### sim/wdog_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Port checks for the supervisory timer
module wdog_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        opt_always_on,
  input wire logic        opt_reset_on_stop,
  input wire logic        stop_exec,
  input wire logic        ext_wake,
  input wire logic        device_reset_n,
  input wire logic        osc_halted
);
  logic [12:0] wk_q; // Halted cycles with wake raised
  logic [12:0] wk_d; // Next count

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================
  // Wake delay counter; cleared once running
  assign wk_d = (osc_halted && ext_wake) ? wk_q + 13'h1 : 13'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_q <= 13'h0;
    end else begin
      wk_q <= wk_d;
    end
  end

  // ==========================================
  // Sequences
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence sw_rst_s;
    psel && penable && pready && pwrite && pstrb[0] && paddr == 8'h24
      && pwdata[7] && !pwdata[6];
  endsequence

  a_ready_setup:
    assert property (setup_s |=> pready) else $error("no ready");
  a_ready_access:
    assert property (pready |-> psel && penable) else $error("stray ready");
  a_unmapped_err:
    assert property (pready && paddr != 8'h24 |-> pslverr && prdata == 0)
      else $error("no slave error");
  a_sw_reset:
    assert property (sw_rst_s |=> !device_reset_n) else $error("no sw reset");
  a_pulse_low:
    assert property ($fell(device_reset_n) |-> !device_reset_n[*8] ##12
      !device_reset_n) else $error("pulse short");
  a_stop_halts:
    assert property (stop_exec && !opt_reset_on_stop && !osc_halted |=>
      osc_halted) else $error("no halt");
  a_stop_reset:
    assert property (stop_exec && opt_reset_on_stop && opt_always_on &&
      !osc_halted |=> !device_reset_n) else $error("no stop reset");
  a_halt_quiet:
    assert property (osc_halted && device_reset_n && !psel && !stop_exec
      |=> device_reset_n) else $error("reset in halt");
  a_wake_delay:
    assert property ($fell(osc_halted) |-> $past(wk_q) inside {[4096:4110]})
      else $error("wake delay");
endmodule

bind windowed_reset_watchdog wdog_chk chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
  .opt_always_on, .opt_reset_on_stop, .stop_exec, .ext_wake,
  .device_reset_n, .osc_halted);

`default_nettype wire

// ### sim/tb_windowed_reset_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Bench for the supervisory timer
module tb_windowed_reset_watchdog;
  localparam int TICK = 16; // Short tick keeps the run brief
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ao, ros, stp, wake, rst_n, halted, e;
  logic [7:0]  paddr;
  logic [3:0]  strb;
  logic [31:0] pwdata, prdata, r;
  int          n, miscompares, comparisons;
  // Written value beside expected readback, all disarmed
  logic [15:0] rows [4] = '{16'h5555, 16'h3F3F, 16'h0000, 16'h7F7F};

  windowed_reset_watchdog #(.TICK_CYC(TICK)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .opt_always_on(ao),
    .opt_reset_on_stop(ros), .stop_exec(stp), .ext_wake(wake),
    .device_reset_n(rst_n), .osc_halted(halted));

  // ==========================================
  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask

  // One free-running tick may land before a readback
  function automatic logic [31:0] near(input logic [31:0] s,
                                       input logic [7:0] x);
    return (s[6:0] == 7'(x[6:0] - 7'h1) && s[31:7] == {24'h0, x[7]}) ?
      {24'h0, x} : s;
  endfunction

  // Wait on a falling edge, where outputs are settled
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    @(negedge pclk);
    while (s !== v && n < lim) begin
      @(negedge pclk);
      n++;
    end
  endtask

  // ==========================================
  // APB transfer; data taken at the ready edge
  task automatic xfer(input logic w, input logic [7:0] a, d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Ready and data read at the edge, before they update
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    r = prdata;
    e = pslverr;
    chk(32'(k < 20), 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst(input logic a, input logic s);
    @(posedge pclk);
    presetn <= 1'b0;
    ao      <= a;
    ros     <= s;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic stop_pulse();
    @(posedge pclk);
    stp <= 1'b1;
    @(posedge pclk);
    stp <= 1'b0;
  endtask

  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #500000;
    miscompares++;
    conclude();
  end

  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, ao, ros, stp, wake} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    strb = 4'hF;
    miscompares = 0;
    comparisons = 0;
    rst(1'b0, 1'b0);
    xfer(1'b0, 8'h24, 8'h00);
    chk(r, 32'h7F);
    xfer(1'b0, 8'h28, 8'h00);
    chk({31'h0, e}, 32'h1);
    foreach (rows[i]) begin
      xfer(1'b1, 8'h24, rows[i][15:8]);
      xfer(1'b0, 8'h24, 8'h00);
      chk(near(r, rows[i][7:0]), {24'h0, rows[i][7:0]});
    end
    // A write without the low byte strobe is ignored
    @(posedge pclk);
    strb <= 4'h0;
    xfer(1'b1, 8'h24, 8'h55);
    strb <= 4'hF;
    xfer(1'b0, 8'h24, 8'h00);
    chk(near(r, 8'h7F), 32'h7F);
    chk({31'h0, rst_n}, 32'h1);
    // Zero written to the activation bit is ignored
    xfer(1'b1, 8'h24, 8'hFF);
    xfer(1'b1, 8'h24, 8'h40);
    xfer(1'b0, 8'h24, 8'h00);
    chk({31'h0, r[7]}, 32'h1);
    wt(rst_n, 1'b0, 40);
    chk(32'(n < 40), 32'h1);
    wt(rst_n, 1'b1, 40);
    xfer(1'b1, 8'h24, 8'h3F);
    wt(rst_n, 1'b0, 3);
    chk(32'(n < 3), 32'h1);
    wt(rst_n, 1'b1, 40);
    // Activation bit written with the top bit clear
    xfer(1'b1, 8'h24, 8'hBF);
    wt(rst_n, 1'b0, 3);
    chk(32'(n < 3), 32'h1);
    wt(rst_n, 1'b1, 40);
    // Short timeout: second tick after loading C1h
    xfer(1'b1, 8'h24, 8'hC1);
    wt(rst_n, 1'b0, 60);
    chk(32'(n >= TICK && n <= 2 * TICK + 3), 32'h1);
    rst(1'b0, 1'b0);
    xfer(1'b0, 8'h24, 8'h00);
    chk(r, 32'h7F);
    // Reload, then stop with no reset option
    xfer(1'b1, 8'h24, 8'hFF);
    stop_pulse();
    repeat (100) @(posedge pclk);
    xfer(1'b0, 8'h24, 8'h00);
    chk(near(r, 8'hFF), 32'hFF);
    chk({31'h0, halted}, 32'h1);
    @(posedge pclk);
    wake <= 1'b1;
    wt(halted, 1'b0, 5000);
    chk(32'(n >= 4096 && n <= 4110), 32'h1);
    @(posedge pclk);
    wake <= 1'b0;
    // Always-on strap with reset on stop
    rst(1'b1, 1'b1);
    // Straps need two edges through the synchroniser
    repeat (2) @(posedge pclk);
    xfer(1'b0, 8'h24, 8'h00);
    chk(r, 32'hFF);
    stop_pulse();
    wt(rst_n, 1'b0, 4);
    chk(32'(n < 4), 32'h1);
    conclude();
  end
endmodule

`default_nettype wire
